/* File: gpm_map.svh */
// Constants for the GPIO port: pin count, pin masks and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH

// Implemented pins on the port
`define GPM_PIN_COUNT 14
// Pins that offer I2C as an alternate function
`define GPM_I2C_PINS 32'h0000000C
// Debug pair reached in alternate function 1
`define GPM_DBG_PAIR_A 32'h00000003
// Debug pair reached in alternate function 2
`define GPM_DBG_PAIR_B 32'h00000300
// Debug clock pins (one per pair)
`define GPM_DBG_CLK_PINS 32'h00000101
// Debug data pins (one per pair)
`define GPM_DBG_DAT_PINS 32'h00000202
// Reset of mode bit 0: debug pair A starts in alternate function 1
`define GPM_MODE0_RST 32'hFFFFFFFC
// Reset of input path enables
`define GPM_IN_EN_RST 32'hFFFFFFFF
// Mode codes (bit2, bit1, bit0)
`define GPM_CODE_AF1 3'h0
`define GPM_CODE_AF2 3'h2
`define GPM_CODE_AF3 3'h3

`endif

/* File: gpm_pkg.sv */
// Types shared by the GPIO port and its bench.
// Assumes gpm_map.svh is on the include path.
`include "gpm_map.svh"

package gpm_pkg;

  // Configuration field chosen by a write
  typedef enum logic [3:0] {
    gpm_f_mode0, gpm_f_mode1, gpm_f_mode2, gpm_f_pull_en, gpm_f_pull_sel,
    gpm_f_out_en, gpm_f_out_lvl, gpm_f_drv_lo, gpm_f_drv_hi, gpm_f_irq_en,
    gpm_f_trig_type, gpm_f_trig_pol, gpm_f_both_edge, gpm_f_in_en
  } gpm_field_t;

  // Pin function after decoding the three mode bits
  typedef enum logic [2:0] {gpm_io, gpm_af1, gpm_af2, gpm_af3, gpm_bad} gpm_mode_t;

  // Any code with bit0 set is a staging form of I/O mode
  function automatic gpm_mode_t gpm_decode(input logic [2:0] code);
    if (code[0]) begin
      return gpm_io;
    end
    unique case (code)
      `GPM_CODE_AF1: return gpm_af1;
      `GPM_CODE_AF2: return gpm_af2;
      default: return gpm_bad;
    endcase
  endfunction : gpm_decode

endpackage : gpm_pkg

/* File: gpm_pin_if.sv */
// Per-pin signals between the port and its interrupt detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface gpm_pin_if #(parameter int N = 14);
  logic [N-1:0] cur;       // Synchronised input
  logic [N-1:0] prev;      // Input one clock earlier
  logic [N-1:0] det_en;    // Detection allowed (I/O mode, input on)
  logic [N-1:0] trig_type; // 0 level, 1 edge
  logic [N-1:0] trig_pol;  // Polarity
  logic [N-1:0] both_edge; // Both edges
  logic [N-1:0] irq_en;    // Per-pin enable
  logic [N-1:0] clear;     // Clear pulse
  logic [N-1:0] set;       // Qualified trigger
  logic [N-1:0] pending;   // Sticky flags

  modport port (output cur, prev, det_en, trig_type, trig_pol, both_edge, irq_en, clear,
                input set, pending);
  modport det (input cur, prev, det_en, trig_type, trig_pol, both_edge, irq_en, clear,
               output set, pending);
endinterface : gpm_pin_if

/* File: gpm_irq_detect.sv */
// Per-pin trigger qualification and sticky pending flags.
// Assumes inputs already synchronised to ref_clk.
`timescale 1ns/1ns

module gpm_irq_detect #(
  parameter int N = 14
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin signals
  gpm_pin_if.det pins
);

  // ****************************************
  // Trigger qualification
  // ****************************************
  for (genvar k = 0; k < N; k++) begin : g_trig
    logic rise;
    logic fall;
    logic lvl_hit;
    logic edge_hit;
    // Compare with the previous sample
    assign rise = pins.cur[k] & ~pins.prev[k];
    assign fall = ~pins.cur[k] & pins.prev[k];
    // High when pol is 1, low when pol is 0
    assign lvl_hit = ~(pins.cur[k] ^ pins.trig_pol[k]);
    // Pol 0 rising, pol 1 falling, or both edges
    assign edge_hit = pins.both_edge[k] ? (rise | fall) :
                      (pins.trig_pol[k] ? fall : rise);
    // Enable gates new triggers only
    assign pins.set[k] = pins.det_en[k] & pins.irq_en[k] &
                         (pins.trig_type[k] ? edge_hit : lvl_hit);
  end

  // ****************************************
  // Pending flags
  // ****************************************
  // A trigger in the clear cycle wins, so no event is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.pending <= '0;
    end else begin
      pins.pending <= pins.set | (pins.pending & ~pins.clear);
    end
  end

endmodule : gpm_irq_detect

/* File: gpm_port.sv */
// One GPIO port: mode selection, pad control, debug pins and interrupts.
// Assumes pads, peripherals and the debug unit outside; config writes
// and clears come from logic on ref_clk, pad inputs are asynchronous.
`timescale 1ns/1ns
`include "gpm_map.svh"

module gpm_port #(
  parameter int N = `GPM_PIN_COUNT,
  parameter logic [N-1:0] I2C_MASK = N'(`GPM_I2C_PINS)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration writes
  input wire logic cfg_wr,
  input wire gpm_pkg::gpm_field_t cfg_field,
  input wire logic [N-1:0] cfg_data,
  // Interrupt clear pulses, one per pin
  input wire logic [N-1:0] irq_clear,
  // System debug disable
  input wire logic debug_disable,
  // Pads
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pull_up,
  output logic [N-1:0] pad_pull_down,
  output logic [N-1:0] pad_drive_hi,
  output logic [N-1:0] pad_drive_lo,
  // Peripheral alternate functions
  input wire logic [N-1:0] af1_out,
  input wire logic [N-1:0] af1_oe,
  input wire logic [N-1:0] af2_out,
  input wire logic [N-1:0] af2_oe,
  input wire logic [N-1:0] af3_out,
  input wire logic [N-1:0] af3_oe,
  output logic [N-1:0] af1_active,
  output logic [N-1:0] af2_active,
  output logic [N-1:0] af3_active,
  // Debug unit
  input wire logic dbg_io_out,
  input wire logic dbg_io_oe,
  output logic dbg_clk,
  output logic dbg_io_in,
  // Status
  output logic [N-1:0] input_level,
  output logic [N-1:0] irq_pending,
  output logic port_irq
);

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [N-1:0] MODE0_RST = N'(`GPM_MODE0_RST);
  localparam logic [N-1:0] IN_EN_RST = N'(`GPM_IN_EN_RST);
  localparam logic [N-1:0] PAIR_A = N'(`GPM_DBG_PAIR_A);
  localparam logic [N-1:0] PAIR_B = N'(`GPM_DBG_PAIR_B);
  localparam logic [N-1:0] CLK_PINS = N'(`GPM_DBG_CLK_PINS);
  localparam logic [N-1:0] DAT_PINS = N'(`GPM_DBG_DAT_PINS);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [N-1:0] mode0_reg; // Mode bit 0
  logic [N-1:0] mode1_reg; // Mode bit 1
  logic [N-1:0] mode2_reg; // Mode bit 2
  logic [N-1:0] pull_en_reg; // Pull resistor on
  logic [N-1:0] pull_sel_reg; // 1 up, 0 down
  logic [N-1:0] out_en_reg; // Output buffer on
  logic [N-1:0] out_lvl_reg; // Output level
  logic [N-1:0] drv_lo_reg; // Drive select low
  logic [N-1:0] drv_hi_reg; // Drive select high
  logic [N-1:0] irq_en_reg; // Interrupt enables
  logic [N-1:0] trig_type_reg; // Level or edge
  logic [N-1:0] trig_pol_reg; // Polarity
  logic [N-1:0] both_edge_reg; // Both edges
  logic [N-1:0] in_en_reg; // Input path on

  // Field written whole; debug pair A starts in function 1, pair B in I/O mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode0_reg <= MODE0_RST;
      mode1_reg <= '0;
      mode2_reg <= '0;
      pull_en_reg <= '0;
      pull_sel_reg <= '0;
      out_en_reg <= '0;
      out_lvl_reg <= '0;
      drv_lo_reg <= '0;
      drv_hi_reg <= '0;
      irq_en_reg <= '0;
      trig_type_reg <= '0;
      trig_pol_reg <= '0;
      both_edge_reg <= '0;
      in_en_reg <= IN_EN_RST;
    end else if (cfg_wr) begin
      unique case (cfg_field)
        gpm_pkg::gpm_f_mode0: mode0_reg <= cfg_data;
        gpm_pkg::gpm_f_mode1: mode1_reg <= cfg_data;
        gpm_pkg::gpm_f_mode2: mode2_reg <= cfg_data;
        gpm_pkg::gpm_f_pull_en: pull_en_reg <= cfg_data;
        gpm_pkg::gpm_f_pull_sel: pull_sel_reg <= cfg_data;
        gpm_pkg::gpm_f_out_en: out_en_reg <= cfg_data;
        gpm_pkg::gpm_f_out_lvl: out_lvl_reg <= cfg_data;
        gpm_pkg::gpm_f_drv_lo: drv_lo_reg <= cfg_data;
        gpm_pkg::gpm_f_drv_hi: drv_hi_reg <= cfg_data;
        gpm_pkg::gpm_f_irq_en: irq_en_reg <= cfg_data;
        gpm_pkg::gpm_f_trig_type: trig_type_reg <= cfg_data;
        gpm_pkg::gpm_f_trig_pol: trig_pol_reg <= cfg_data;
        gpm_pkg::gpm_f_both_edge: both_edge_reg <= cfg_data;
        gpm_pkg::gpm_f_in_en: in_en_reg <= cfg_data;
        default: begin
          // Unused field codes write nothing
        end
      endcase
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [N-1:0] sync1_reg; // First stage, read only by second
  logic [N-1:0] sync2_reg; // Safe sample
  logic [N-1:0] prev_reg; // Previous safe sample

  // Two flops before use, a third for edge history
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ****************************************
  // Per-pin decode
  // ****************************************
  wire [N-1:0] oe_next; // Pad enable to register
  wire [N-1:0] out_next; // Pad level to register
  wire [N-1:0] dbg_on; // Pin owned by the debug unit
  wire [N-1:0] io_like; // Pin behaves as I/O
  wire [N-1:0] af1_sel; // Function 1 owns pin
  wire [N-1:0] af2_sel; // Function 2 owns pin
  wire [N-1:0] af3_sel; // Function 3 owns pin

  for (genvar k = 0; k < N; k++) begin : g_pin
    gpm_pkg::gpm_mode_t mode;
    logic dbg_slot;
    // Staging codes decode as I/O
    assign mode = gpm_pkg::gpm_decode({mode2_reg[k], mode1_reg[k], mode0_reg[k]});
    // Debug pairs live in different functions
    assign dbg_slot = (PAIR_A[k] & (mode == gpm_pkg::gpm_af1)) |
                      (PAIR_B[k] & (mode == gpm_pkg::gpm_af2));
    assign dbg_on[k] = dbg_slot & ~debug_disable;
    // Disabled debug hands the pin back as I/O
    assign io_like[k] = (mode == gpm_pkg::gpm_io) | (dbg_slot & debug_disable);
    assign af1_sel[k] = (mode == gpm_pkg::gpm_af1) & ~dbg_slot;
    assign af2_sel[k] = (mode == gpm_pkg::gpm_af2) & ~dbg_slot;
    assign af3_sel[k] = (mode == gpm_pkg::gpm_af3);
    // Only debug data pins drive; clock pins stay inputs
    assign oe_next[k] = dbg_on[k] ? (DAT_PINS[k] & dbg_io_oe) :
                        io_like[k] ? out_en_reg[k] :
                        af1_sel[k] ? af1_oe[k] :
                        af2_sel[k] ? af2_oe[k] :
                        af3_sel[k] ? af3_oe[k] : 1'b0;
    assign out_next[k] = dbg_on[k] ? dbg_io_out :
                         io_like[k] ? out_lvl_reg[k] :
                         af1_sel[k] ? af1_out[k] :
                         af2_sel[k] ? af2_out[k] :
                         af3_sel[k] ? af3_out[k] : 1'b0;
  end

  // ****************************************
  // Pad outputs
  // ****************************************
  // Registered so every pad line comes from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_pull_up <= '0;
      pad_pull_down <= '0;
      pad_drive_hi <= '0;
      pad_drive_lo <= '0;
    end else begin
      pad_out <= out_next;
      pad_oe <= oe_next;
      // No pull unless enabled; I2C pins lose the pullup
      pad_pull_up <= pull_en_reg & pull_sel_reg & ~I2C_MASK;
      pad_pull_down <= pull_en_reg & ~pull_sel_reg;
      // I2C pads ignore the high bit: low bit picks 2 or 10mA
      pad_drive_hi <= drv_hi_reg & ~I2C_MASK;
      pad_drive_lo <= drv_lo_reg;
    end
  end

  // ****************************************
  // Function and debug routing
  // ****************************************
  // Owners are told which pins they hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      af1_active <= '0;
      af2_active <= '0;
      af3_active <= '0;
      dbg_clk <= 1'b0;
      dbg_io_in <= 1'b0;
    end else begin
      af1_active <= af1_sel;
      af2_active <= af2_sel;
      af3_active <= af3_sel;
      // Both pairs can hold their debug slots at once; their pins are ORed
      dbg_clk <= |(dbg_on & CLK_PINS & sync2_reg);
      dbg_io_in <= |(dbg_on & DAT_PINS & sync2_reg);
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  gpm_pin_if #(.N(N)) pin_bus ();

  assign pin_bus.cur = sync2_reg;
  assign pin_bus.prev = prev_reg;
  // Detection only in I/O mode with the input path on
  assign pin_bus.det_en = io_like & in_en_reg;
  assign pin_bus.trig_type = trig_type_reg;
  assign pin_bus.trig_pol = trig_pol_reg;
  assign pin_bus.both_edge = both_edge_reg;
  assign pin_bus.irq_en = irq_en_reg;
  assign pin_bus.clear = irq_clear;

  gpm_irq_detect #(.N(N)) u_detect (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pins(pin_bus.det)
  );

  assign irq_pending = pin_bus.pending;

  // ****************************************
  // Status outputs
  // ****************************************
  // Input level also valid under a function; line follows enabled flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_level <= '0;
      port_irq <= 1'b0;
    end else begin
      input_level <= sync2_reg & in_en_reg;
      port_irq <= |(pin_bus.pending & irq_en_reg);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Input level follows synchronised pins two flops later
  a_input_level_path: assert property (
    input_level == ($past(sync1_reg, 2) & $past(in_en_reg)))
    else $error("input level does not follow pin");

  // Shared line tracks enabled pending flags
  a_port_irq_any: assert property (
    port_irq == $past(|(irq_pending & irq_en_reg)))
    else $error("port interrupt mismatch");

  // Pullup never reaches an I2C pin
  a_no_i2c_pullup: assert property (
    (pad_pull_up & I2C_MASK) == '0)
    else $error("pullup on I2C pin");

  // I2C pins never see the high drive bit
  a_i2c_drive_low: assert property (
    (pad_drive_hi & I2C_MASK) == '0)
    else $error("high drive bit on I2C pin");

  // Pending only falls through a clear pulse
  a_pending_holds: assert property (
    ($past(irq_pending & ~irq_clear) & ~irq_pending) == '0)
    else $error("pending flag lost without clear");

  // Clear without trigger empties the flag
  a_clear_pending: assert property (
    ($past(irq_clear & ~pin_bus.set) & irq_pending) == '0)
    else $error("pending flag survived clear");

  // Level trigger at matching level sets the flag
  a_level_sets: assert property (
    ($past(pin_bus.det_en & irq_en_reg & ~trig_type_reg & ~(sync2_reg ^ trig_pol_reg))
      & ~irq_pending) == '0)
    else $error("level trigger missed");

  // Rising edge with polarity 0 or both edges sets the flag
  a_rise_sets: assert property (
    ($past(pin_bus.det_en & irq_en_reg & trig_type_reg & sync2_reg & ~prev_reg
      & (~trig_pol_reg | both_edge_reg)) & ~irq_pending) == '0)
    else $error("rising edge missed");

  // No new flag from a disabled or non-I/O pin
  a_gated_trigger: assert property (
    ((irq_pending & ~$past(irq_pending)) & ~$past(pin_bus.det_en & irq_en_reg)) == '0)
    else $error("flag set while gated");

  // I/O pins drive their output enable one clock on
  a_io_drive: assert property (
    ($past(io_like & ~dbg_on & out_en_reg) & ~pad_oe) == '0)
    else $error("I/O output not driven");

  c_port_irq_rise: cover property ($rose(port_irq));
  c_dbg_pair_b: cover property (|(dbg_on & PAIR_B));
  c_clear_race: cover property (|(irq_clear & pin_bus.set));
  c_both_edges: cover property (|(both_edge_reg & pin_bus.set & ~sync2_reg));

endmodule : gpm_port

/* File: gpm_far_side.sv */
// Far side of the port: pad wires with outside drivers and weak pulls.
// Assumes the bench changes ext_drv and ext_val on ref_clk edges.
`timescale 1ns/1ns

module gpm_far_side #(
  parameter int N = 14
) (
  // Clock
  input wire logic ref_clk,
  // Pad controls from the port
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pull_up,
  input wire logic [N-1:0] pad_pull_down,
  // Outside drivers
  input wire logic [N-1:0] ext_drv,
  input wire logic [N-1:0] ext_val,
  // Resolved pin levels
  output logic [N-1:0] pad_in
);
  // ************
  // Pin resolution
  // ************
  logic [N-1:0] float_reg = {N{1'b0}}; // Undriven pins flip every cycle

  // A floating pin must never look like a stable level
  always @(posedge ref_clk) begin
    float_reg <= ~float_reg;
  end

  // Port drive wins, then the outside driver, then the pulls
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_drv[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pull_up[i] || pad_pull_down[i]) begin
        pad_in[i] = pad_pull_up[i];
      end else begin
        pad_in[i] = float_reg[i];
      end
    end
  end
endmodule : gpm_far_side

/* File: gpio_port_mode_irq_bench.sv */
// Bench for the GPIO port: field model in the bench, pads via gpm_far_side.
// Assumes the port's default N of 14 and its I2C pin mask.
`timescale 1ns/1ns
`include "gpm_map.svh"

module gpio_port_mode_irq_bench;
  localparam logic [13:0] I2C = 14'(`GPM_I2C_PINS); // Pins without pullup
  // Clock, reset and control
  logic ref_clk = 1'b0;
  logic rst_n, cfg_wr, debug_disable, dbg_io_out, dbg_io_oe, dbg_clk, dbg_io_in, port_irq, e;
  gpm_pkg::gpm_field_t cfg_field;
  // Per-pin vectors
  logic [13:0] cfg_data, irq_clear, pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [13:0] pad_drive_hi, pad_drive_lo, af1_out, af1_oe, af2_out, af2_oe, af3_out, af3_oe;
  logic [13:0] af1_active, af2_active, af3_active, input_level, irq_pending, ext_drv, ext_val;
  logic [13:0] m [0:13]; // Model of every field, indexed by field code
  logic [13:0] eo, ed, ea1, ea2, pm; // Expected pad values
  logic edc, edi; // Expected debug clock and data seen by the debug unit
  logic [31:0] seed;
  int bad_count, checked, k;

  always #25 ref_clk = ~ref_clk;

  gpm_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_field(cfg_field), .cfg_data(cfg_data),
    .irq_clear(irq_clear), .debug_disable(debug_disable), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_drive_hi(pad_drive_hi),
    .pad_drive_lo(pad_drive_lo), .af1_out(af1_out), .af1_oe(af1_oe), .af2_out(af2_out), .af2_oe(af2_oe),
    .af3_out(af3_out), .af3_oe(af3_oe), .af1_active(af1_active), .af2_active(af2_active),
    .af3_active(af3_active), .dbg_io_out(dbg_io_out), .dbg_io_oe(dbg_io_oe), .dbg_clk(dbg_clk),
    .dbg_io_in(dbg_io_in), .input_level(input_level), .irq_pending(irq_pending), .port_irq(port_irq));

  gpm_far_side far (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));

  // ************
  // Helpers
  // ************
  // Xorshift source, fixed start
  function automatic logic [13:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[13:0];
  endfunction : rnd

  // Wait, then let the edge's updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // One field write, mirrored in the model
  task automatic wr(input gpm_pkg::gpm_field_t f, input logic [13:0] d);
    @(posedge ref_clk);
    // Enum field kept out of the concatenation so strict tools accept it
    cfg_wr <= 1'b1;
    cfg_field <= f;
    cfg_data <= d;
    m[f] = d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask : wr

  // Clear pulse on every pin
  task automatic clr();
    @(posedge ref_clk);
    irq_clear <= 14'h3FFF;
    @(posedge ref_clk);
    irq_clear <= 14'h0000;
    cyc(3);
  endtask : clr

  // Drive pins k and k+1 together
  task automatic drv(input logic v);
    @(posedge ref_clk);
    ext_val <= v ? (14'h0003 << k) : 14'h0000;
    cyc(5);
  endtask : drv

  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk

  // Only pin k may ever be pending; the line follows it
  task automatic chk_irq(input logic v);
    chk(irq_pending, 14'(v) << k, "pending");
    chk({13'h0000, port_irq}, {13'h0000, v}, "port irq");
  endtask : chk_irq

  // Expected pad drive from the model, per pin
  task automatic expect_pads();
    logic [2:0] c;
    logic sl;
    {edc, edi} = 2'h0;
    for (int p = 0; p < 14; p++) begin
      c = {m[2][p], m[1][p], m[0][p]};
      sl = (p < 2 && c == 3'h0) || ((p == 8 || p == 9) && c == 3'h2);
      {eo[p], ed[p], ea1[p], ea2[p]} = 4'h0;
      if (sl && !debug_disable) begin
        {eo[p], ed[p]} = {(p == 1 || p == 9) && dbg_io_oe, dbg_io_out};
        // Clock pins are inputs; a data pin reads back its own drive when enabled
        edc = edc | ((p == 0 || p == 8) && ext_val[p]);
        edi = edi | ((p == 1 || p == 9) && (eo[p] ? ed[p] : ext_val[p]));
      end else if (c[0] || sl) begin
        {eo[p], ed[p]} = {m[5][p], m[6][p]};
      end else if (c == 3'h0) begin
        {eo[p], ed[p], ea1[p]} = {af1_oe[p], af1_out[p], 1'b1};
      end else if (c == 3'h2) begin
        {eo[p], ed[p], ea2[p]} = {af2_oe[p], af2_out[p], 1'b1};
      end
    end
  endtask : expect_pads

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ************
  // Sequence
  // ************
  // Watchdog well beyond the expected run
  initial begin
    #(50 * 20000);
    bad_count++;
    close_out();
  end

  initial begin
    seed = 32'h00000E5F;
    {rst_n, cfg_wr, cfg_data, irq_clear} = {2'h0, 28'h0000000};
    cfg_field = gpm_pkg::gpm_f_mode0;
    {debug_disable, dbg_io_out, dbg_io_oe, ext_drv, ext_val} = {3'h0, 14'h3FFF, 14'h0000};
    {af1_out, af1_oe, af2_out, af2_oe, af3_out, af3_oe} = {6{14'h0000}};
    for (int i = 0; i < 14; i++) begin
      m[i] = 14'h0000;
    end
    {m[0], m[13]} = {14'h3FFC, 14'h3FFF};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    // Defaults after reset
    chk(pad_oe, 14'h0000, "reset oe");
    chk(pad_pull_up | pad_pull_down | pad_drive_hi | pad_drive_lo, 14'h0000, "reset pads");
    chk(irq_pending | af1_active | {13'h0000, port_irq}, 14'h0000, "reset irq");
    @(posedge ref_clk);
    {dbg_io_oe, dbg_io_out} <= 2'h3;
    cyc(2);
    chk(pad_oe, 14'h0002, "debug data oe");
    chk(pad_out & 14'h0002, 14'h0002, "debug data");
    dbg_io_oe <= 1'b0;
    wr(gpm_pkg::gpm_f_mode0, 14'h3FFF);
    // Pulls and drive codes, pins left to the pulls
    ext_drv <= 14'h0000;
    for (int i = 0; i < 3; i++) begin
      wr(gpm_pkg::gpm_f_pull_en, rnd());
      wr(gpm_pkg::gpm_f_pull_sel, rnd());
      wr(gpm_pkg::gpm_f_drv_lo, rnd());
      wr(gpm_pkg::gpm_f_drv_hi, rnd());
      cyc(5);
      pm = m[3] & ~(I2C & m[4]);
      chk(pad_pull_up, m[3] & m[4] & ~I2C, "pull up");
      chk(pad_pull_down & pm, m[3] & ~m[4], "pull down");
      chk(input_level & pm, m[3] & m[4] & ~I2C, "pulled level");
      chk(pad_drive_hi, m[8] & ~I2C, "drive hi");
      chk(pad_drive_lo, m[7], "drive lo");
    end
    // Input level in I/O mode and in function 1
    ext_drv <= 14'h3FFF;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      ext_val <= rnd();
      wr(gpm_pkg::gpm_f_in_en, rnd());
      wr(gpm_pkg::gpm_f_mode0, i == 0 ? 14'h3FFF : 14'h0000);
      cyc(5);
      chk(input_level, ext_val & m[13], "input level");
    end
    wr(gpm_pkg::gpm_f_in_en, 14'h3FFF);
    // Mode decode, debug slots and function ownership
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      {af1_out, af1_oe, af2_out, af2_oe, af3_out, af3_oe} <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      pm = rnd();
      {dbg_io_out, dbg_io_oe, debug_disable} <= pm[2:0];
      wr(gpm_pkg::gpm_f_out_en, rnd());
      wr(gpm_pkg::gpm_f_out_lvl, rnd());
      wr(gpm_pkg::gpm_f_mode0, 14'h3FFF);
      wr(gpm_pkg::gpm_f_mode1, i < 8 ? {14{i[1]}} : rnd());
      wr(gpm_pkg::gpm_f_mode2, i < 8 ? {14{i[2]}} : rnd());
      wr(gpm_pkg::gpm_f_mode0, i < 8 ? {14{i[0]}} : rnd());
      // Pad flop, two sync flops and the debug output flop
      cyc(4);
      expect_pads();
      chk({12'h000, dbg_clk, dbg_io_in}, {12'h000, edc, edi}, "debug inputs");
      chk(pad_oe, eo, "pad oe");
      chk(pad_out & eo, ed & eo, "pad out");
      chk(af1_active, ea1, "af1 owner");
      chk(af2_active, ea2, "af2 owner");
      chk(af3_active, 14'h0000, "af3 owner");
    end
    // Interrupts on pin k, pin k+1 toggles unenabled
    @(posedge ref_clk);
    {af1_oe, af2_oe, af3_oe, ext_val} <= {4{14'h0000}};
    wr(gpm_pkg::gpm_f_mode1, 14'h0000);
    wr(gpm_pkg::gpm_f_mode2, 14'h0000);
    wr(gpm_pkg::gpm_f_mode0, 14'h3FFF);
    wr(gpm_pkg::gpm_f_out_en, 14'h0000);
    k = 4 + int'(rnd() & 14'h0007);
    wr(gpm_pkg::gpm_f_irq_en, 14'h0001 << k);
    for (int c = 0; c < 8; c++) begin
      wr(gpm_pkg::gpm_f_trig_type, {14{c[0]}});
      wr(gpm_pkg::gpm_f_trig_pol, {14{c[1]}});
      wr(gpm_pkg::gpm_f_both_edge, {14{c[2]}});
      drv(1'b0);
      clr();
      e = !c[0] && !c[1];
      chk_irq(e);
      drv(1'b1);
      e = e | (!c[0] && c[1]) | (c[0] && (c[2] || !c[1]));
      chk_irq(e);
      clr();
      e = !c[0] && c[1];
      chk_irq(e);
      drv(1'b0);
      e = e | (!c[0] && !c[1]) | (c[0] && (c[2] || c[1]));
      chk_irq(e);
    end
    // Disable keeps the flag and stops new ones
    wr(gpm_pkg::gpm_f_irq_en, 14'h0000);
    cyc(2);
    chk(irq_pending, 14'h0001 << k, "kept flag");
    chk({13'h0000, port_irq}, 14'h0000, "masked line");
    clr();
    drv(1'b1);
    chk_irq(1'b0);
    wr(gpm_pkg::gpm_f_irq_en, 14'h0001 << k);
    drv(1'b0);
    chk_irq(1'b1);
    // No detection in function mode or with input off
    clr();
    wr(gpm_pkg::gpm_f_mode0, ~(14'h0001 << k));
    drv(1'b1);
    chk_irq(1'b0);
    wr(gpm_pkg::gpm_f_mode0, 14'h3FFF);
    wr(gpm_pkg::gpm_f_in_en, ~(14'h0001 << k));
    drv(1'b0);
    chk_irq(1'b0);
    wr(gpm_pkg::gpm_f_in_en, 14'h3FFF);
    drv(1'b1);
    chk_irq(1'b1);
    close_out();
  end
endmodule : gpio_port_mode_irq_bench
